// *** src/fch_host.sv ***
// Notes on behaviour
// - Reset is F0 at any address
// - Program: 555/AA, 2AA/55, 555/A0, location/value
// - Byte mode uses AAA and 555 instead
// - Bypass enter, A0-program, 90/00 exit
// - Chip erase: six writes ending 555/10
// - Sector erase: sixth write sector/30
// - B0 suspends sector erase, 30 resumes
// - Autoselect left only by reset
// - After timeout bit, host writes reset
// - Unlock pair plus 90 enters autoselect
// - Address at later fall, data earlier rise
// - Byte pin selects byte or word bus
module fch_host #(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_data,
   input wire logic byte_mode,
   output logic cmd_ready_q,
   output logic rsp_valid_q,
   output logic [DATA_W-1:0] rsp_data_q,
   output logic [ADDR_W-1:0] fl_addr_q,
   input wire logic [DATA_W-1:0] fl_dq_in,
   output logic [DATA_W-1:0] fl_dq_out_q,
   output logic fl_dq_oe_q,
   output logic fl_ce_n_q,
   output logic fl_we_n_q,
   output logic fl_oe_n_q,
   output logic fl_byte_n_q
);
   initial begin
      if (ADDR_W < 19 || DATA_W != 16) begin
         $error("fch_host: ADDR_W must be at least 19 and DATA_W 16");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command to write list

   localparam int MAX_STEPS = 6;
   localparam int CNT_W = fch_pkg::CNT_W;

   logic [ADDR_W-1:0] st_addr_q [MAX_STEPS];
   logic [7:0] st_data_q [MAX_STEPS];
   logic [2:0] st_count_q;
   logic [2:0] st_idx_q;
   logic st_read_q;
   logic st_last_data_wide_q;
   logic [DATA_W-1:0] st_wide_q;
   fch_pkg::fch_phase_t phase_q;
   logic [CNT_W-1:0] cnt_q;
   logic [2:0] sync_q;
   logic [DATA_W-1:0] dq_s1_q;
   logic [DATA_W-1:0] dq_s2_q;
   logic [DATA_W-1:0] dq_s3_q;
   logic [DATA_W-1:0] dq_agree_q;

   // Unlock address in the current bus width
   function automatic logic [ADDR_W-1:0] unl_adr(input logic first, input logic bmode);
      logic [11:0] a;
      a = bmode ? (first ? fch_pkg::ADR_B_FIRST : fch_pkg::ADR_B_SECOND)
                : (first ? fch_pkg::ADR_W_FIRST : fch_pkg::ADR_W_SECOND);
      unl_adr = {{(ADDR_W-12){1'b0}}, a};
   endfunction : unl_adr

   // Sector address with a low offset, only the sector field above the offset kept
   function automatic logic [ADDR_W-1:0] sec_adr(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
      logic [ADDR_W-1:0] r;
      r = '0;
      r[fch_pkg::SECTOR_LSB +: fch_pkg::SECTOR_BITS] = a[fch_pkg::SECTOR_LSB +: fch_pkg::SECTOR_BITS];
      r[11:0] = ofs;
      sec_adr = r;
   endfunction : sec_adr

   logic start;
   assign start = cmd_valid && cmd_ready_q;

   // Load the write list for an accepted command
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_count_q <= 3'h0;
         st_read_q <= 1'b0;
         st_last_data_wide_q <= 1'b0;
         st_wide_q <= 16'h0000;
         fl_byte_n_q <= 1'b1;
         for (int i = 0; i < MAX_STEPS; i++) begin
            st_addr_q[i] <= '0;
            st_data_q[i] <= 8'h00;
         end
      end else if (start) begin
         fl_byte_n_q <= !byte_mode;
         st_read_q <= 1'b0;
         st_last_data_wide_q <= 1'b0;
         st_wide_q <= cmd_data;
         st_addr_q[0] <= unl_adr(1'b1, byte_mode);
         st_data_q[0] <= fch_pkg::DAT_UNLOCK1;
         st_addr_q[1] <= unl_adr(1'b0, byte_mode);
         st_data_q[1] <= fch_pkg::DAT_UNLOCK2;
         st_addr_q[2] <= unl_adr(1'b1, byte_mode);
         st_addr_q[3] <= unl_adr(1'b1, byte_mode);
         st_data_q[3] <= fch_pkg::DAT_UNLOCK1;
         st_addr_q[4] <= unl_adr(1'b0, byte_mode);
         st_data_q[4] <= fch_pkg::DAT_UNLOCK2;
         st_addr_q[5] <= unl_adr(1'b1, byte_mode);
         case (fch_pkg::fch_op_t'(cmd_op))
            fch_pkg::FCH_OP_READ: begin
               st_count_q <= 3'h1;
               st_read_q <= 1'b1;
               st_addr_q[0] <= cmd_addr;
            end
            fch_pkg::FCH_OP_RESET: begin
               st_count_q <= 3'h1;
               st_addr_q[0] <= cmd_addr;
               st_data_q[0] <= fch_pkg::DAT_RESET;
            end
            fch_pkg::FCH_OP_PROGRAM: begin
               st_count_q <= 3'h4;
               st_data_q[2] <= fch_pkg::DAT_PROGRAM;
               st_addr_q[3] <= cmd_addr;
               st_last_data_wide_q <= 1'b1;
            end
            fch_pkg::FCH_OP_BYP_ENTER: begin
               st_count_q <= 3'h3;
               st_data_q[2] <= fch_pkg::DAT_BYPASS;
            end
            fch_pkg::FCH_OP_BYP_PROGRAM: begin
               st_count_q <= 3'h2;
               st_addr_q[0] <= cmd_addr;
               st_data_q[0] <= fch_pkg::DAT_PROGRAM;
               st_addr_q[1] <= cmd_addr;
               st_last_data_wide_q <= 1'b1;
            end
            fch_pkg::FCH_OP_BYP_EXIT: begin
               st_count_q <= 3'h2;
               st_addr_q[0] <= cmd_addr;
               st_data_q[0] <= fch_pkg::DAT_AUTOSEL;
               st_addr_q[1] <= cmd_addr;
               st_data_q[1] <= fch_pkg::DAT_BYP_EXIT;
            end
            fch_pkg::FCH_OP_CHIP_ERASE: begin
               st_count_q <= 3'h6;
               st_data_q[2] <= fch_pkg::DAT_ERASE_SETUP;
               st_data_q[5] <= fch_pkg::DAT_CHIP_ERASE;
            end
            fch_pkg::FCH_OP_SECTOR_ERASE: begin
               st_count_q <= 3'h6;
               st_data_q[2] <= fch_pkg::DAT_ERASE_SETUP;
               st_addr_q[5] <= sec_adr(cmd_addr, 12'h000);
               st_data_q[5] <= fch_pkg::DAT_SECTOR_ERASE;
            end
            fch_pkg::FCH_OP_SUSPEND: begin
               st_count_q <= 3'h1;
               st_addr_q[0] <= cmd_addr;
               st_data_q[0] <= fch_pkg::DAT_SUSPEND;
            end
            fch_pkg::FCH_OP_RESUME: begin
               st_count_q <= 3'h1;
               st_addr_q[0] <= cmd_addr;
               st_data_q[0] <= fch_pkg::DAT_RESUME;
            end
            fch_pkg::FCH_OP_AUTOSEL: begin
               st_count_q <= 3'h3;
               st_data_q[2] <= fch_pkg::DAT_AUTOSEL;
            end
            fch_pkg::FCH_OP_ID_MAKER: begin
               st_count_q <= 3'h1;
               st_read_q <= 1'b1;
               st_addr_q[0] <= {{(ADDR_W-12){1'b0}}, fch_pkg::ID_MAKER_OFS};
            end
            fch_pkg::FCH_OP_ID_DEVICE: begin
               st_count_q <= 3'h1;
               st_read_q <= 1'b1;
               st_addr_q[0] <= {{(ADDR_W-12){1'b0}},
                                byte_mode ? fch_pkg::ID_DEV_B_OFS : fch_pkg::ID_DEV_W_OFS};
            end
            fch_pkg::FCH_OP_ID_PROTECT: begin
               st_count_q <= 3'h1;
               st_read_q <= 1'b1;
               st_addr_q[0] <= sec_adr(cmd_addr,
                                       byte_mode ? fch_pkg::ID_PROT_B_OFS : fch_pkg::ID_PROT_W_OFS);
            end
            default: begin
               st_count_q <= 3'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus cycle sequencer

   logic last_step;
   assign last_step = (st_idx_q == st_count_q - 3'h1);
   logic done;
   assign done = (phase_q == fch_pkg::FCH_PH_HOLD) && (cnt_q == '0) && last_step;

   // address before strobe falls, data held past rise
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= fch_pkg::FCH_PH_IDLE;
         cnt_q <= '0;
         st_idx_q <= 3'h0;
         cmd_ready_q <= 1'b1;
      end else begin
         case (phase_q)
            fch_pkg::FCH_PH_IDLE: begin
               if (start) begin
                  cmd_ready_q <= 1'b0;
                  st_idx_q <= 3'h0;
                  // Unknown op yields a zero-length list
                  if (cmd_op > 4'hD) begin
                     cmd_ready_q <= 1'b1;
                  end else begin
                     phase_q <= fch_pkg::FCH_PH_SETUP;
                     cnt_q <= CNT_W'(fch_pkg::SETUP_CYC - 1);
                  end
               end
            end
            fch_pkg::FCH_PH_SETUP: begin
               if (cnt_q == '0) begin
                  phase_q <= fch_pkg::FCH_PH_PULSE;
                  cnt_q <= CNT_W'(fch_pkg::PULSE_CYC - 1);
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            fch_pkg::FCH_PH_PULSE: begin
               if (cnt_q == '0) begin
                  phase_q <= fch_pkg::FCH_PH_HOLD;
                  cnt_q <= CNT_W'(fch_pkg::HOLD_CYC - 1);
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            fch_pkg::FCH_PH_HOLD: begin
               if (cnt_q != '0) begin
                  cnt_q <= cnt_q - 1'b1;
               end else if (last_step) begin
                  phase_q <= fch_pkg::FCH_PH_IDLE;
                  cmd_ready_q <= 1'b1;
               end else begin
                  st_idx_q <= st_idx_q + 3'h1;
                  phase_q <= fch_pkg::FCH_PH_SETUP;
                  cnt_q <= CNT_W'(fch_pkg::SETUP_CYC - 1);
               end
            end
            default: begin
               phase_q <= fch_pkg::FCH_PH_IDLE;
               cmd_ready_q <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pins

   logic active;
   assign active = (phase_q != fch_pkg::FCH_PH_IDLE);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fl_addr_q <= '0;
         fl_dq_out_q <= 16'h0000;
         fl_dq_oe_q <= 1'b0;
         fl_ce_n_q <= 1'b1;
         fl_we_n_q <= 1'b1;
         fl_oe_n_q <= 1'b1;
      end else begin
         fl_addr_q <= st_addr_q[st_idx_q];
         fl_dq_out_q <= (last_step && st_last_data_wide_q) ? st_wide_q : {8'h00, st_data_q[st_idx_q]};
         // Select drops with ready rising; it asserts one cycle after ready falls
         fl_ce_n_q <= !active || done;
         fl_we_n_q <= !(phase_q == fch_pkg::FCH_PH_PULSE && !st_read_q);
         fl_oe_n_q <= !(phase_q == fch_pkg::FCH_PH_PULSE && st_read_q);
         fl_dq_oe_q <= active && !st_read_q;
      end
   end

   // Read data crosses in from the pins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1_q <= 16'h0000;
         dq_s2_q <= 16'h0000;
         dq_s3_q <= 16'h0000;
         dq_agree_q <= 16'h0000;
      end else begin
         dq_s1_q <= fl_dq_in;
         dq_s2_q <= dq_s1_q;
         dq_s3_q <= dq_s2_q;
         // A bit moves only once the last two stages agree
         dq_agree_q <= (dq_s2_q & dq_s3_q) | (dq_agree_q & (dq_s2_q | dq_s3_q));
      end
   end

   // Sample at the end of the read strobe; after it the bus is released
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q <= 16'h0000;
      end else begin
         rsp_valid_q <= 1'b0;
         if (st_read_q && phase_q == fch_pkg::FCH_PH_PULSE && cnt_q == '0) begin
            rsp_valid_q <= 1'b1;
            rsp_data_q <= fl_byte_n_q ? dq_agree_q : {8'h00, dq_agree_q[7:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_we_oe_exclusive: assert property (@(posedge mclk) disable iff (!rst_n)
      !(!fl_we_n_q && !fl_oe_n_q)) else $error("write and read strobes overlap");

   sequence s_accept;
      cmd_valid && cmd_ready_q;
   endsequence

   a_reset_value: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_accept and cmd_op == 4'h1) |-> ##[1:60] (!fl_we_n_q && fl_dq_out_q[7:0] == 8'hF0))
      else $error("reset write missing");

   // chip select low while strobe low
   a_ce_frames_we: assert property (@(posedge mclk) disable iff (!rst_n)
      !fl_we_n_q |-> !fl_ce_n_q) else $error("strobe outside chip select");

   a_read_answer: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_accept and cmd_op == 4'h0) |=> !cmd_ready_q ##[1:60] rsp_valid_q)
      else $error("read answer missing");

   a_no_drive_on_read: assert property (@(posedge mclk) disable iff (!rst_n)
      !fl_oe_n_q |-> !fl_dq_oe_q) else $error("bus driven during read");

   // write data stable over strobe rise
   a_data_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      ($rose(fl_we_n_q)) |-> $stable(fl_dq_out_q) && fl_dq_oe_q) else $error("data moved at strobe rise");

   a_addr_stable: assert property (@(posedge mclk) disable iff (!rst_n)
      (!fl_we_n_q && $past(!fl_we_n_q)) |-> $stable(fl_addr_q)) else $error("address moved in strobe");

   a_busy_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
      !fl_ce_n_q |-> !cmd_ready_q) else $error("ready during bus cycle");

endmodule : fch_host

// *** src/fch_pkg.sv ***
package fch_pkg;
   // Command addresses, word mode and byte mode
   localparam logic [11:0] ADR_W_FIRST = 12'h555;
   localparam logic [11:0] ADR_W_SECOND = 12'h2AA;
   localparam logic [11:0] ADR_B_FIRST = 12'hAAA;
   localparam logic [11:0] ADR_B_SECOND = 12'h555;
   // Command data values
   localparam logic [7:0] DAT_UNLOCK1 = 8'hAA;
   localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
   localparam logic [7:0] DAT_RESET = 8'hF0;
   localparam logic [7:0] DAT_PROGRAM = 8'hA0;
   localparam logic [7:0] DAT_BYPASS = 8'h20;
   localparam logic [7:0] DAT_AUTOSEL = 8'h90;
   localparam logic [7:0] DAT_BYP_EXIT = 8'h00;
   localparam logic [7:0] DAT_ERASE_SETUP = 8'h80;
   localparam logic [7:0] DAT_CHIP_ERASE = 8'h10;
   localparam logic [7:0] DAT_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] DAT_SUSPEND = 8'hB0;
   localparam logic [7:0] DAT_RESUME = 8'h30;
   // Autoselect read offsets
   localparam logic [11:0] ID_MAKER_OFS = 12'h000;
   localparam logic [11:0] ID_DEV_W_OFS = 12'h001;
   localparam logic [11:0] ID_DEV_B_OFS = 12'h002;
   localparam logic [11:0] ID_PROT_W_OFS = 12'h002;
   localparam logic [11:0] ID_PROT_B_OFS = 12'h004;
   // Sector field of the word address
   localparam int SECTOR_LSB = 12;
   localparam int SECTOR_BITS = 7;
   // Bus cycle timing in mclk cycles
   localparam int T_SETUP_NS = 40;
   localparam int T_PULSE_NS = 80;
   localparam int T_HOLD_NS = 40;
   localparam int CLK_NS = 4;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 6;
   // Host commands
   typedef enum logic [3:0] {
      FCH_OP_READ = 4'h0,
      FCH_OP_RESET = 4'h1,
      FCH_OP_PROGRAM = 4'h2,
      FCH_OP_BYP_ENTER = 4'h3,
      FCH_OP_BYP_PROGRAM = 4'h4,
      FCH_OP_BYP_EXIT = 4'h5,
      FCH_OP_CHIP_ERASE = 4'h6,
      FCH_OP_SECTOR_ERASE = 4'h7,
      FCH_OP_SUSPEND = 4'h8,
      FCH_OP_RESUME = 4'h9,
      FCH_OP_AUTOSEL = 4'hA,
      FCH_OP_ID_MAKER = 4'hB,
      FCH_OP_ID_DEVICE = 4'hC,
      FCH_OP_ID_PROTECT = 4'hD
   } fch_op_t;
   // Bus cycle phases, Gray along the usual path
   typedef enum logic [1:0] {
      FCH_PH_IDLE = 2'b00,
      FCH_PH_SETUP = 2'b01,
      FCH_PH_PULSE = 2'b11,
      FCH_PH_HOLD = 2'b10
   } fch_phase_t;
endpackage : fch_pkg

// *** test/fch_flash_model.sv ***
module fch_flash_model #(
   parameter logic [15:0] MAKER = 16'h0042, // Arbitrary maker value
   parameter logic [15:0] DEV_ID = 16'h1234, // Arbitrary device value
   parameter logic [15:0] STAT = 16'h0044,
   parameter logic [6:0] PROT_SEC = 7'h11,
   parameter int ERASE_STEPS = 30
) (
   input wire logic [18:0] addr,
   input wire logic [15:0] host_dq,
   input wire logic host_oe,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic byte_n,
   output logic [15:0] dq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [logic [18:0]];
   logic [18:0] a_lat;
   logic [15:0] dev_q;
   logic [15:0] junk = 16'h0001;
   logic [7:0] cd;
   logic [11:0] fa;
   logic [11:0] sa;
   logic asel = 1'b0;
   logic byp = 1'b0;
   logic susp = 1'b0;
   logic chip = 1'b0;
   logic [6:0] esec;
   int st = 0;
   int er_left = 0;
   wire wr = !ce_n && !we_n && oe_n;
   ////////////////////////////////////////////////////////////
   // read path
   function automatic logic [15:0] rd_val(input logic [18:0] a);
      if (er_left > 0 && (!susp || a[18:12] == esec))
         return STAT;
      if (asel) begin
         if (a[11:0] == 12'h000)
            return MAKER;
         if (a[11:0] == (byte_n ? 12'h001 : 12'h002))
            return DEV_ID;
         if (a[11:0] == (byte_n ? 12'h002 : 12'h004))
            return {15'h0000, a[18:12] == PROT_SEC};
         return 16'h0000;
      end
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   task automatic prog(input logic [18:0] a, input logic [15:0] d);
      logic [15:0] old;
      old = mem.exists(a) ? mem[a] : 16'hFFFF;
      if (a[18:12] != PROT_SEC && !(susp && a[18:12] == esec))
         mem[a] = old & (byte_n ? d : {8'hFF, d[7:0]});
   endtask
   ////////////////////////////////////////////////////////////
   // Released bus wanders so stale data never passes
   always #3 junk = {junk[14:0], ~junk[15]};
   always #1 dev_q = rd_val(addr);
   // byte mode drives low lines only
   assign dq = host_oe ? host_dq : (!ce_n && !oe_n) ? (byte_n ? dev_q : {junk[15:8], dev_q[7:0]}) : junk;
   always @(posedge wr) a_lat = addr;
   always @(negedge wr) begin
      cd = dq[7:0];
      fa = byte_n ? 12'h555 : 12'hAAA;
      sa = byte_n ? 12'h2AA : 12'h555;
      if (er_left > 0 && !susp) begin
         if (cd == 8'hB0 && !chip)
            susp = 1'b1;
      // Program data of F0 is data, not a reset
      end else if (cd == 8'hF0 && st != 3 && st != 7) begin
         st = 0;
         asel = 1'b0;
      end else if (!asel) begin
         case (st)
            0: begin
               if (byp && cd == 8'hA0)
                  st = 7;
               else if (byp && cd == 8'h90)
                  st = 8;
               else if (susp && cd == 8'h30)
                  susp = 1'b0;
               else if (a_lat[11:0] == fa && cd == 8'hAA)
                  st = 1;
            end
            1, 4: st = (a_lat[11:0] == sa && cd == 8'h55) ? st + 1 : 0;
            2: begin
               st = 0;
               if (a_lat[11:0] == fa && cd == 8'hA0)
                  st = 3;
               if (a_lat[11:0] == fa && cd == 8'h20)
                  byp = 1'b1;
               if (a_lat[11:0] == fa && cd == 8'h90)
                  asel = 1'b1;
               if (a_lat[11:0] == fa && cd == 8'h80)
                  st = 9;
            end
            3, 7: begin
               prog(a_lat, dq);
               st = 0;
            end
            8: begin
               if (cd == 8'h00)
                  byp = 1'b0;
               st = 0;
            end
            9: st = (a_lat[11:0] == fa && cd == 8'hAA) ? 4 : 0;
            5: begin
               st = 0;
               if ((cd == 8'h10 && a_lat[11:0] == fa) || cd == 8'h30) begin
                  chip = (cd == 8'h10);
                  esec = a_lat[18:12];
                  er_left = ERASE_STEPS;
               end
            end
            default: st = 0;
         endcase
      end
   end
   always #100 begin
      if (er_left > 0 && !susp) begin
         er_left--;
         if (er_left == 0)
            foreach (mem[k])
               if (chip || k[18:12] == esec)
                  mem[k] = 16'hFFFF;
      end
   end
endmodule : fch_flash_model

// *** test/flash_command_state_machine_test.sv ***
module flash_command_state_machine_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] MAKER = 16'h0042; // Arbitrary maker value
   localparam logic [15:0] DEV_ID = 16'h1234; // Arbitrary device value
   localparam logic [15:0] STAT = 16'h0044;
   localparam logic [6:0] PROT_SEC = 7'h11;
   localparam logic [18:0] A1 = 19'h05010;
   localparam logic [18:0] A2 = 19'h06020;
   localparam logic [18:0] A3 = 19'h05FFF;
   logic mclk;
   logic rst_n;
   logic cmd_valid;
   logic byte_mode;
   logic [3:0] cmd_op;
   logic [18:0] cmd_addr;
   logic [15:0] cmd_data;
   logic cmd_ready_q;
   logic rsp_valid_q;
   logic fl_dq_oe_q;
   logic fl_ce_n_q;
   logic fl_we_n_q;
   logic fl_oe_n_q;
   logic fl_byte_n_q;
   logic [15:0] rsp_data_q;
   logic [15:0] fl_dq_out_q;
   logic [15:0] fl_dq;
   logic [18:0] fl_addr_q;
   int mismatches = 0;
   int n_checks = 0;

   fch_host #(.ADDR_W(19), .DATA_W(16)) i_dut (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .byte_mode(byte_mode),
      .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .fl_addr_q(fl_addr_q),
      .fl_dq_in(fl_dq), .fl_dq_out_q(fl_dq_out_q), .fl_dq_oe_q(fl_dq_oe_q), .fl_ce_n_q(fl_ce_n_q),
      .fl_we_n_q(fl_we_n_q), .fl_oe_n_q(fl_oe_n_q), .fl_byte_n_q(fl_byte_n_q));
   fch_flash_model #(.MAKER(MAKER), .DEV_ID(DEV_ID), .STAT(STAT), .PROT_SEC(PROT_SEC), .ERASE_STEPS(30))
      i_flash (.addr(fl_addr_q), .host_dq(fl_dq_out_q), .host_oe(fl_dq_oe_q), .ce_n(fl_ce_n_q),
      .we_n(fl_we_n_q), .oe_n(fl_oe_n_q), .byte_n(fl_byte_n_q), .dq(fl_dq));
   ////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Request held until taken; response caught while waiting for idle
   task automatic op(input logic [3:0] code, input logic [18:0] a, input logic [15:0] d, output logic [15:0] r);
      int n;
      r = 16'hXXXX;
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_op <= code;
      cmd_addr <= a;
      cmd_data <= d;
      do @(posedge mclk); while (cmd_ready_q !== 1'b1);
      cmd_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         if (rsp_valid_q === 1'b1)
            r = rsp_data_q;
         n++;
      end while (cmd_ready_q !== 1'b1 && n < 2000);
      @(posedge mclk);
      if (rsp_valid_q === 1'b1)
         r = rsp_data_q;
      if (n >= 2000) begin
         mismatches++;
         $display("mismatch at %0t: command never completed", $time);
      end
   endtask : op

   // Poll until the erase status clears, bounded
   task automatic wait_done(input logic [18:0] a);
      logic [15:0] r;
      int n = 0;
      do begin
         op(fch_pkg::FCH_OP_READ, a, 16'h0000, r);
         n++;
      end while (r === STAT && n < 100);
   endtask : wait_done
   ////////////////////////////////////////////////////////////
   task automatic t_idle();
      chk({10'h000, fl_ce_n_q, fl_we_n_q, fl_oe_n_q, fl_byte_n_q, cmd_ready_q, fl_dq_oe_q}, 16'h003E);
   endtask : t_idle

   task automatic t_program();
      logic [15:0] r;
      op(fch_pkg::FCH_OP_READ, A1, 16'h0000, r);
      chk(r, 16'hFFFF);
      op(fch_pkg::FCH_OP_PROGRAM, A1, 16'hC3A5, r);
      op(fch_pkg::FCH_OP_PROGRAM, A2, 16'hABCD, r);
      op(fch_pkg::FCH_OP_READ, A1, 16'h0000, r);
      chk(r, 16'hC3A5);
      op(fch_pkg::FCH_OP_READ, A2, 16'h0000, r);
      chk(r, 16'hABCD);
   endtask : t_program

   task automatic t_byte();
      logic [15:0] r;
      byte_mode <= 1'b1;
      op(fch_pkg::FCH_OP_PROGRAM, 19'h07000, 16'h3C5A, r);
      op(fch_pkg::FCH_OP_READ, 19'h07000, 16'h0000, r);
      chk(r, 16'h005A);
      byte_mode <= 1'b0;
   endtask : t_byte

   task automatic t_autosel();
      logic [15:0] r;
      for (int bm = 0; bm < 2; bm++) begin
         byte_mode <= bm[0];
         op(fch_pkg::FCH_OP_AUTOSEL, 19'h00000, 16'h0000, r);
         op(fch_pkg::FCH_OP_ID_MAKER, 19'h00000, 16'h0000, r);
         chk(r, MAKER);
         op(fch_pkg::FCH_OP_ID_DEVICE, 19'h00000, 16'h0000, r);
         chk(r, bm ? {8'h00, DEV_ID[7:0]} : DEV_ID);
         op(fch_pkg::FCH_OP_ID_PROTECT, {PROT_SEC, 12'h000}, 16'h0000, r);
         chk(r, 16'h0001);
         op(fch_pkg::FCH_OP_ID_PROTECT, {PROT_SEC ^ 7'h01, 12'h000}, 16'h0000, r);
         chk(r, 16'h0000);
         op(fch_pkg::FCH_OP_READ, A1, 16'h0000, r);
         chk(r, 16'h0000);
         op(fch_pkg::FCH_OP_RESET, A3, 16'h0000, r);
         op(fch_pkg::FCH_OP_READ, A1, 16'h0000, r);
         chk(r, bm ? 16'h00A5 : 16'hC3A5);
      end
      byte_mode <= 1'b0;
   endtask : t_autosel

   task automatic t_bypass();
      logic [15:0] r;
      op(fch_pkg::FCH_OP_BYP_ENTER, 19'h00000, 16'h0000, r);
      op(fch_pkg::FCH_OP_BYP_PROGRAM, A3, 16'h00F0, r);
      op(fch_pkg::FCH_OP_BYP_PROGRAM, 19'h05002, 16'h7777, r);
      op(fch_pkg::FCH_OP_BYP_EXIT, 19'h00000, 16'h0000, r);
      op(fch_pkg::FCH_OP_READ, A3, 16'h0000, r);
      chk(r, 16'h00F0);
      op(fch_pkg::FCH_OP_READ, 19'h05002, 16'h0000, r);
      chk(r, 16'h7777);
   endtask : t_bypass

   // Reset ignored once erasing; suspend, program elsewhere, resume
   task automatic t_erase();
      logic [15:0] r;
      op(fch_pkg::FCH_OP_SECTOR_ERASE, A1, 16'h0000, r);
      op(fch_pkg::FCH_OP_RESET, 19'h00000, 16'h0000, r);
      op(fch_pkg::FCH_OP_READ, A2, 16'h0000, r);
      chk(r, STAT);
      op(fch_pkg::FCH_OP_SUSPEND, 19'h00000, 16'h0000, r);
      op(fch_pkg::FCH_OP_READ, A2, 16'h0000, r);
      chk(r, 16'hABCD);
      op(fch_pkg::FCH_OP_READ, A3, 16'h0000, r);
      chk(r, STAT);
      op(fch_pkg::FCH_OP_PROGRAM, 19'h06100, 16'h1111, r);
      op(fch_pkg::FCH_OP_READ, 19'h06100, 16'h0000, r);
      chk(r, 16'h1111);
      op(fch_pkg::FCH_OP_RESUME, 19'h00000, 16'h0000, r);
      wait_done(A3);
      op(fch_pkg::FCH_OP_READ, A1, 16'h0000, r);
      chk(r, 16'hFFFF);
      op(fch_pkg::FCH_OP_READ, A2, 16'h0000, r);
      chk(r, 16'hABCD);
   endtask : t_erase

   task automatic t_chip();
      logic [15:0] r;
      op(fch_pkg::FCH_OP_CHIP_ERASE, 19'h00000, 16'h0000, r);
      op(fch_pkg::FCH_OP_SUSPEND, 19'h00000, 16'h0000, r);
      op(fch_pkg::FCH_OP_READ, A2, 16'h0000, r);
      chk(r, STAT);
      wait_done(A2);
      op(fch_pkg::FCH_OP_READ, A2, 16'h0000, r);
      chk(r, 16'hFFFF);
      op(fch_pkg::FCH_OP_READ, 19'h06100, 16'h0000, r);
      chk(r, 16'hFFFF);
   endtask : t_chip
   ////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = 4'h0;
      cmd_addr = 19'h00000;
      cmd_data = 16'h0000;
      byte_mode = 1'b0;
      repeat (3) @(posedge mclk);
      t_idle();
      rst_n <= 1'b1;
      t_program();
      t_byte();
      t_autosel();
      t_bypass();
      t_erase();
      t_chip();
      give_verdict();
   end

   // Whole run needs roughly 5k cycles
   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end
endmodule : flash_command_state_machine_test
